// ===== design/boot_chain_pkg.sv
// Constants and field layouts for the target address and boot chain block
package boot_chain_pkg;

    // ---------------------------------------------------------------
    // Register offsets
    // ---------------------------------------------------------------
    localparam logic [31:0] OFF_TARGET_ADDR = 32'h0001_D100;
    localparam logic [31:0] OFF_BOOT_CTRL = 32'h0001_D140;
    localparam logic [31:0] OFF_DIAG_PROGRESS = 32'h0001_D144;
    localparam logic [31:0] OFF_DIAG_CONFIG = 32'h0001_D148;

    // ---------------------------------------------------------------
    // Target address register, bit 0 of the word is the lsb
    // ---------------------------------------------------------------
    typedef struct packed {
        logic [1:0] rsv_a;
        logic alert_enable;
        logic target_respond_enable;
        logic [2:0] rsv_b;
        logic target_addr_low_unlock;
        logic [16:0] rsv_c;
        logic [6:0] own_target_address;
    } target_reg_s;

    localparam logic [6:0] TARGET_ADDR_RESET = 7'h30;
    localparam logic TARGET_EN_RESET = 1'b1;
    localparam int TARGET_UNLOCK_BIT = 24;

    // ---------------------------------------------------------------
    // Boot load control register
    // ---------------------------------------------------------------
    typedef struct packed {
        logic chain;
        logic offset_width_select;
        logic page_select_increment;
        logic boot_addr_low_unlock;
        logic [4:0] rsv;
        logic [6:0] boot_device_addr;
        logic [2:0] page_mode;
        logic [12:0] offset;
    } boot_ctrl_s;

    localparam int BOOT_UNLOCK_BIT = 28;
    localparam logic [6:0] BOOT_DEV_RESET = 7'h50;
    localparam logic [12:0] BOOT_OFFSET_RESET = 13'h0000;
    localparam logic [2:0] PAGE_MODE_RESET = 3'h0;
    localparam logic PAGE_SELECT_INCREMENT_RESET = 1'b1;

    // ---------------------------------------------------------------
    // Boot sequencer
    // ---------------------------------------------------------------
    typedef enum logic [5:0] {
        ST_STRAP = 6'b00_0001,
        ST_HEADER = 6'b00_0010,
        ST_ENT_ADDR = 6'b00_0100,
        ST_ENT_DATA = 6'b00_1000,
        ST_APPLY = 6'b01_0000,
        ST_DONE = 6'b10_0000
    } boot_state_e;

    localparam logic [1:0] STRAP_WAIT = 2'd3;
    localparam logic [12:0] WORD_STEP = 13'h0004;

endpackage : boot_chain_pkg

// ===== design/pin_sync2.sv
// Two flip-flop synchroniser for strap pins
`timescale 1ns/1ps
`default_nettype none

module pin_sync2 #(
    parameter int WIDTH = 2
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] pin_out
);

    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] next_stage1;
    logic [WIDTH-1:0] next_pin_out;

    always_comb
    begin
        next_stage1 = rstn ? pin_in : '0;
        next_pin_out = rstn ? stage1 : '0;
    end

    always_ff @(posedge clk)
    begin
        stage1 <= next_stage1;
        pin_out <= next_pin_out;
    end

endmodule // pin_sync2

`default_nettype wire

// ===== design/target_addr_match.sv
// Decides acknowledge for the address byte seen by the I2C target
`timescale 1ns/1ps
`default_nettype none

module target_addr_match (
    input wire logic [6:0] own_target_address,
    input wire logic target_respond_enable,
    input wire logic addr_byte_valid,
    input wire logic [7:0] addr_byte,
    output logic addr_ack,
    output logic general_call
);

    logic [6:0] seen;

    always_comb
    begin
        seen = addr_byte[7:1];
        // Address zero is start byte and general call, never ours
        general_call = addr_byte_valid && (seen == 7'h00); // RULE5
        addr_ack = addr_byte_valid
            && target_respond_enable // RULE1 RULE17
            && (own_target_address != 7'h00) // RULE5
            && !general_call // RULE6
            && (seen == own_target_address); // RULE1
    end

endmodule // target_addr_match

`default_nettype wire

// ===== design/i2c_slave_addr_boot_chain_ctrl.sv
// Target address register and boot chain loader with its control register
// Function
// (RULE1) Answer as target at own address only while respond enable is set.
// (RULE2) Capture two low target address bits from pins at power-up.
// (RULE3) Low target address bits ignore writes unless unlock written one.
// (RULE4) Target address resets to 0x30, low bits then taken from pins.
// (RULE5) Address zero is never a valid device address.
// (RULE6) General call is ignored and not acknowledged.
// (RULE7) Every reset starts a boot load steered by control reset values.
// (RULE8) Some boot control fields take power-up values from pins.
// (RULE9) EEPROM data may write boot control to redirect the load.
// (RULE10) After boot the control register is storage only.
// (RULE11) Chain only when chain bit written with remaining count zero.
// (RULE12) Other field writes store but do not alter sequence without chain.
// (RULE13) Chain bit is bit 00 (word msb), resets to zero.
// (RULE14) Boot control sits at offset 0x1D140 with its listed fields.
// (RULE15) Progress and configuration diagnostics expose the load.
// (RULE16) Writer sets unlock in the same write as new low bits.
// (RULE17) With respond enable clear, all addressed transactions are refused.
// (RULE18) Boot load reads EEPROM at current device and offset in order.
`timescale 1ns/1ps
`default_nettype none

module i2c_slave_addr_boot_chain_ctrl
    import boot_chain_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic [1:0] target_addr_pins,
    input wire logic [1:0] boot_addr_pins,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    output logic reg_ack,
    input wire logic addr_byte_valid,
    input wire logic [7:0] addr_byte,
    output logic addr_ack,
    output logic general_call,
    output logic eeprom_req,
    output logic [6:0] eeprom_dev,
    output logic [12:0] eeprom_offset,
    output logic eeprom_wide,
    input wire logic eeprom_ack,
    input wire logic eeprom_err,
    input wire logic [31:0] eeprom_data,
    output logic boot_wr_valid,
    output logic [31:0] boot_wr_addr,
    output logic [31:0] boot_wr_data,
    output logic boot_busy,
    output logic boot_error
);

    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    target_reg_s target_reg, next_target_reg;
    boot_ctrl_s boot_ctrl, next_boot_ctrl, wr_ctrl;
    boot_state_e state, next_state;
    logic [1:0] strap_cnt, next_strap_cnt, target_pins_s, boot_pins_s;
    logic [15:0] load_count, next_load_count, chains, next_chains;
    logic [6:0] cur_dev, next_cur_dev;
    logic [12:0] cur_off, next_cur_off;
    logic cur_wide, next_cur_wide, next_boot_error, next_boot_wr_valid;
    logic next_reg_ack, chain_now;
    logic [31:0] ent_addr, next_ent_addr, ent_data, next_ent_data;
    logic [31:0] next_boot_wr_addr, next_boot_wr_data, next_reg_rdata;
    // Write sources: index 0 software, index 1 boot engine
    logic [1:0] wr_en;
    logic [31:0] wr_addr [2], wr_data [2];

    // ---------------------------------------------------------------
    // Pin synchronisers, address decode and boot engine outputs
    // ---------------------------------------------------------------
    pin_sync2 #(.WIDTH(2)) u_sync_target (
        .clk(clk),
        .rstn(rstn),
        .pin_in(target_addr_pins),
        .pin_out(target_pins_s)
    );

    pin_sync2 #(.WIDTH(2)) u_sync_boot (
        .clk(clk),
        .rstn(rstn),
        .pin_in(boot_addr_pins),
        .pin_out(boot_pins_s)
    );

    target_addr_match u_match (
        .own_target_address(target_reg.own_target_address),
        .target_respond_enable(target_reg.target_respond_enable),
        .addr_byte_valid(addr_byte_valid),
        .addr_byte(addr_byte),
        .addr_ack(addr_ack),
        .general_call(general_call)
    );

    always_comb
    begin
        // Sequential reads from the current device and offset
        eeprom_req = (state == ST_HEADER) || (state == ST_ENT_ADDR)
            || (state == ST_ENT_DATA); // RULE18
        eeprom_dev = cur_dev;
        eeprom_offset = cur_off;
        eeprom_wide = cur_wide;
        boot_busy = (state != ST_DONE);
    end

    // ---------------------------------------------------------------
    // Next state of registers and sequencer
    // ---------------------------------------------------------------
    always_comb
    begin
        next_target_reg = target_reg;
        next_boot_ctrl = boot_ctrl;
        next_state = state;
        next_strap_cnt = strap_cnt;
        next_load_count = load_count;
        next_cur_dev = cur_dev;
        next_cur_off = cur_off;
        next_cur_wide = cur_wide;
        next_ent_addr = ent_addr;
        next_ent_data = ent_data;
        next_boot_error = boot_error;
        next_boot_wr_valid = 1'b0;
        next_boot_wr_addr = boot_wr_addr;
        next_boot_wr_data = boot_wr_data;
        next_chains = chains;
        chain_now = 1'b0;
        wr_ctrl = boot_ctrl;

        wr_en[0] = reg_wr;
        wr_addr[0] = reg_addr;
        wr_data[0] = reg_wdata;
        wr_en[1] = (state == ST_APPLY); // RULE9
        wr_addr[1] = ent_addr;
        wr_data[1] = ent_data;

        // Boot engine write is applied last so it wins a collision
        for (int s = 0; s < 2; s++)
        begin
            if (wr_en[s] && wr_addr[s] == OFF_TARGET_ADDR)
            begin
                next_target_reg.alert_enable = wr_data[s][29];
                next_target_reg.target_respond_enable = wr_data[s][28];
                next_target_reg.target_addr_low_unlock =
                    wr_data[s][TARGET_UNLOCK_BIT];
                next_target_reg.own_target_address[6:2] = wr_data[s][6:2];
                if (wr_data[s][TARGET_UNLOCK_BIT]) // RULE3 RULE16
                begin
                    next_target_reg.own_target_address[1:0] =
                        wr_data[s][1:0];
                end
            end
            if (wr_en[s] && wr_addr[s] == OFF_BOOT_CTRL) // RULE14
            begin
                wr_ctrl = boot_ctrl_s'(wr_data[s]);
                next_boot_ctrl.chain = wr_ctrl.chain; // RULE13
                next_boot_ctrl.offset_width_select =
                    wr_ctrl.offset_width_select;
                next_boot_ctrl.page_select_increment =
                    wr_ctrl.page_select_increment;
                next_boot_ctrl.boot_addr_low_unlock =
                    wr_ctrl.boot_addr_low_unlock;
                next_boot_ctrl.boot_device_addr[6:2] =
                    wr_ctrl.boot_device_addr[6:2];
                if (wr_data[s][BOOT_UNLOCK_BIT])
                begin
                    next_boot_ctrl.boot_device_addr[1:0] =
                        wr_ctrl.boot_device_addr[1:0];
                end
                next_boot_ctrl.page_mode = wr_ctrl.page_mode;
                next_boot_ctrl.offset = wr_ctrl.offset; // RULE12
            end
        end

        case (state)
            ST_STRAP:
            begin
                next_strap_cnt = strap_cnt + 2'd1;
                if (strap_cnt == STRAP_WAIT)
                begin
                    // Pins have passed the synchroniser by now
                    next_target_reg.own_target_address[1:0] =
                        target_pins_s; // RULE2 RULE4
                    next_boot_ctrl.boot_device_addr[1:0] =
                        boot_pins_s; // RULE8
                    // First load follows the reset contents
                    next_cur_dev = {boot_ctrl.boot_device_addr[6:2],
                        boot_pins_s}; // RULE7
                    next_cur_off = boot_ctrl.offset;
                    next_cur_wide = boot_ctrl.offset_width_select;
                    next_state = ST_HEADER;
                end
            end
            ST_HEADER, ST_ENT_ADDR, ST_ENT_DATA:
            begin
                if (eeprom_ack && eeprom_err)
                begin
                    next_boot_error = 1'b1;
                    next_state = ST_DONE;
                end
                else if (eeprom_ack)
                begin
                    next_cur_off = cur_off + WORD_STEP; // RULE18
                    if (state == ST_HEADER)
                    begin
                        next_load_count = eeprom_data[15:0];
                        next_state = (eeprom_data[15:0] == 16'h0000)
                            ? ST_DONE : ST_ENT_ADDR;
                    end
                    else if (state == ST_ENT_ADDR)
                    begin
                        next_ent_addr = eeprom_data;
                        next_state = ST_ENT_DATA;
                    end
                    else
                    begin
                        next_ent_data = eeprom_data;
                        next_state = ST_APPLY;
                    end
                end
            end
            ST_APPLY:
            begin
                next_load_count = load_count - 16'h0001;
                if (ent_addr == OFF_BOOT_CTRL)
                begin
                    // Chain only from the last entry of this device
                    chain_now = wr_ctrl.chain
                        && (load_count == 16'h0001); // RULE11
                end
                else if (ent_addr != OFF_TARGET_ADDR)
                begin
                    next_boot_wr_valid = 1'b1;
                    next_boot_wr_addr = ent_addr;
                    next_boot_wr_data = ent_data;
                end
                if (chain_now)
                begin
                    next_cur_dev = next_boot_ctrl.boot_device_addr; // RULE9
                    next_cur_off = next_boot_ctrl.offset;
                    next_cur_wide = next_boot_ctrl.offset_width_select;
                    next_chains = chains + 16'h0001;
                    next_state = ST_HEADER;
                end
                else if (load_count == 16'h0001)
                begin
                    next_state = ST_DONE;
                end
                else
                begin
                    next_state = ST_ENT_ADDR;
                end
            end
            ST_DONE:
            begin
                // Register is storage only from here on
                next_state = ST_DONE; // RULE10
            end
            default:
            begin
                next_state = ST_DONE;
            end
        endcase

        next_reg_ack = reg_wr || reg_rd;
        next_reg_rdata = 32'h0000_0000;
        if (reg_rd)
        begin
            case (reg_addr)
                OFF_TARGET_ADDR: next_reg_rdata = target_reg;
                OFF_BOOT_CTRL: next_reg_rdata = boot_ctrl;
                OFF_DIAG_PROGRESS: next_reg_rdata =
                    {state, boot_error, boot_busy, 8'h00, load_count}; // RULE15
                OFF_DIAG_CONFIG: next_reg_rdata =
                    {chains[10:0], cur_wide, cur_dev, cur_off}; // RULE15
                default: next_reg_rdata = 32'h0000_0000;
            endcase
        end

        if (!rstn)
        begin
            next_target_reg = '0;
            next_target_reg.own_target_address = TARGET_ADDR_RESET; // RULE4
            next_target_reg.target_respond_enable = TARGET_EN_RESET;
            next_boot_ctrl = '0; // RULE13
            next_boot_ctrl.page_select_increment = PAGE_SELECT_INCREMENT_RESET;
            next_boot_ctrl.boot_device_addr = BOOT_DEV_RESET;
            next_boot_ctrl.page_mode = PAGE_MODE_RESET;
            next_boot_ctrl.offset = BOOT_OFFSET_RESET;
            next_state = ST_STRAP; // RULE7
            next_strap_cnt = 2'd0;
            next_load_count = 16'h0000;
            next_cur_dev = 7'h00;
            next_cur_off = 13'h0000;
            next_cur_wide = 1'b0;
            next_ent_addr = 32'h0000_0000;
            next_ent_data = 32'h0000_0000;
            next_boot_error = 1'b0;
            next_boot_wr_valid = 1'b0;
            next_boot_wr_addr = 32'h0000_0000;
            next_boot_wr_data = 32'h0000_0000;
            next_chains = 16'h0000;
            next_reg_ack = 1'b0;
            next_reg_rdata = 32'h0000_0000;
        end
    end

    // ---------------------------------------------------------------
    // Registers
    // ---------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        target_reg <= next_target_reg;
        boot_ctrl <= next_boot_ctrl;
        state <= next_state;
        strap_cnt <= next_strap_cnt;
        load_count <= next_load_count;
        cur_dev <= next_cur_dev;
        cur_off <= next_cur_off;
        cur_wide <= next_cur_wide;
        ent_addr <= next_ent_addr;
        ent_data <= next_ent_data;
        boot_error <= next_boot_error;
        boot_wr_valid <= next_boot_wr_valid;
        boot_wr_addr <= next_boot_wr_addr;
        boot_wr_data <= next_boot_wr_data;
        chains <= next_chains;
        reg_ack <= next_reg_ack;
        reg_rdata <= next_reg_rdata;
    end

endmodule // i2c_slave_addr_boot_chain_ctrl

`default_nettype wire

// ===== bench/boot_chain_asserts.sv
// Concurrent checks on the target address and boot chain block
`timescale 1ns/1ps
`default_nettype none

module boot_chain_asserts (
    input wire logic clk,
    input wire logic rstn,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic reg_ack,
    input wire logic [31:0] reg_rdata,
    input wire logic addr_byte_valid,
    input wire logic [7:0] addr_byte,
    input wire logic addr_ack,
    input wire logic general_call,
    input wire logic eeprom_req,
    input wire logic [6:0] eeprom_dev,
    input wire logic [12:0] eeprom_offset,
    input wire logic eeprom_ack,
    input wire logic eeprom_err,
    input wire logic boot_busy,
    input wire logic boot_error
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    chk_gc_no_ack:
        assert property (general_call |-> !addr_ack)
        else $error("general call acknowledged");
    chk_gc_cause:
        assert property (general_call |-> addr_byte_valid
            && addr_byte[7:1] == 7'h00)
        else $error("general call flag without address zero");
    chk_ack_cause:
        assert property (addr_ack |-> addr_byte_valid
            && addr_byte[7:1] != 7'h00)
        else $error("acknowledge without a valid nonzero address");
    chk_reg_answer:
        assert property (reg_wr || reg_rd |=> reg_ack)
        else $error("register access not answered");
    chk_rdata_quiet:
        assert property (!reg_ack |-> reg_rdata == 32'h0000_0000)
        else $error("read data outside acknowledge");
    chk_boot_start:
        assert property ($rose(rstn) |-> boot_busy ##[1:8] eeprom_req)
        else $error("boot load did not start after reset");
    chk_req_hold:
        assert property (eeprom_req && !eeprom_ack
            |=> $stable(eeprom_dev) && $stable(eeprom_offset))
        else $error("read request moved before acknowledge");
    chk_word_step:
        assert property (eeprom_req && eeprom_ack && !eeprom_err
            |=> eeprom_offset == $past(eeprom_offset) + 13'h0004)
        else $error("offset did not step by one word");
    chk_err_stop:
        assert property (eeprom_req && eeprom_ack && eeprom_err
            |=> boot_error && !boot_busy)
        else $error("read error did not end the load");
    chk_idle_quiet:
        assert property (!boot_busy |-> !eeprom_req)
        else $error("read request after load ended");

    cover property (general_call);
    cover property (eeprom_ack && eeprom_err);
    cover property ($fell(boot_busy) && !boot_error);
endmodule // boot_chain_asserts

bind i2c_slave_addr_boot_chain_ctrl boot_chain_asserts chk_i (
    .clk, .rstn, .reg_wr, .reg_rd, .reg_ack, .reg_rdata,
    .addr_byte_valid, .addr_byte, .addr_ack, .general_call,
    .eeprom_req, .eeprom_dev, .eeprom_offset, .eeprom_ack,
    .eeprom_err, .boot_busy, .boot_error
);
`default_nettype wire

// ===== bench/eeprom_model.sv
// Serial EEPROM read engine model holding a chained boot image
`timescale 1ns/1ps
`default_nettype none

module eeprom_model (
    input wire logic clk,
    input wire logic rstn,
    input wire logic slow,
    input wire logic fail,
    input wire logic eeprom_req,
    input wire logic [6:0] eeprom_dev,
    input wire logic [12:0] eeprom_offset,
    output logic eeprom_ack,
    output logic eeprom_err,
    output logic [31:0] eeprom_data
);
    logic [1:0] cnt;

    // Chain entry is last in its image and carries low device bits 00
    function automatic logic [31:0] image(input logic [19:0] key);
        case (key)
            20'h5_1000: return 32'h0000_0002;
            20'h5_1004: return 32'h0000_1234;
            20'h5_1008: return 32'hA5A5_0001;
            20'h5_100C: return 32'h0001_D140;
            20'h5_1010: return 32'hA054_0010;
            20'h5_5010: return 32'h0000_0001;
            20'h5_5014: return 32'h0000_2000;
            20'h5_5018: return 32'h5555_AAAA;
            default: return 32'h0000_0000;
        endcase
    endfunction

    initial
    begin
        eeprom_ack = 1'b0;
        eeprom_err = 1'b0;
        eeprom_data = 32'h0000_0000;
        cnt = 2'd0;
    end

    always @(posedge clk)
    begin
        eeprom_ack <= 1'b0;
        eeprom_err <= 1'b0;
        // Data outside an acknowledge inverts every cycle, so it never stays on one word
        eeprom_data <= ~eeprom_data;
        if (!rstn || !eeprom_req || eeprom_ack)
            cnt <= 2'd0;
        else if (cnt >= (slow ? 2'd3 : 2'd0))
        begin
            eeprom_ack <= 1'b1;
            eeprom_err <= fail;
            eeprom_data <= image({1'b0, eeprom_dev, eeprom_offset[11:0]});
            cnt <= 2'd0;
        end
        else
            cnt <= cnt + 2'd1;
    end
endmodule // eeprom_model
`default_nettype wire

// ===== bench/i2c_slave_addr_boot_chain_ctrl_bench.sv
// Self-checking bench for the target address and boot chain block
`timescale 1ns/1ps
`default_nettype none

module i2c_slave_addr_boot_chain_ctrl_bench;
    import boot_chain_pkg::*;
    logic clk, rstn, reg_wr, reg_rd, addr_byte_valid, slow, fail, en;
    logic reg_ack, addr_ack, general_call, eeprom_req, eeprom_wide;
    logic eeprom_ack, eeprom_err, boot_wr_valid, boot_busy, boot_error;
    logic [1:0] target_addr_pins, boot_addr_pins;
    logic [31:0] reg_addr, reg_wdata, reg_rdata, eeprom_data;
    logic [31:0] boot_wr_addr, boot_wr_data;
    logic [7:0] addr_byte;
    logic [6:0] eeprom_dev, own;
    logic [12:0] eeprom_offset;
    logic [32:0] note;
    logic [32:0] rd_q[$];
    logic [63:0] bw_q[$];
    int error_cnt = 0;
    int checked = 0;

    always #2.5 clk = ~clk;

    i2c_slave_addr_boot_chain_ctrl uut (.clk, .rstn, .target_addr_pins,
        .boot_addr_pins, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
        .reg_rdata, .reg_ack, .addr_byte_valid, .addr_byte, .addr_ack,
        .general_call, .eeprom_req, .eeprom_dev, .eeprom_offset,
        .eeprom_wide, .eeprom_ack, .eeprom_err, .eeprom_data,
        .boot_wr_valid, .boot_wr_addr, .boot_wr_data, .boot_busy,
        .boot_error);
    eeprom_model far_i (.clk, .rstn, .slow, .fail, .eeprom_req,
        .eeprom_dev, .eeprom_offset, .eeprom_ack, .eeprom_err,
        .eeprom_data);

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        checked++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up;
        $display("checked %0d error_cnt %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic tick;
        @(posedge clk);
        #1;
    endtask

    // Write when wr is set, else read with d as the expected word
    task automatic reg_acc(input logic wr, input logic [31:0] a, d);
        rd_q.push_back({!wr, d});
        reg_wr = wr;
        reg_rd = !wr;
        reg_addr = a;
        reg_wdata = d;
        tick();
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        tick();
    endtask

    task automatic do_reset(input logic [1:0] tp, bp);
        rstn = 1'b0;
        target_addr_pins = tp;
        boot_addr_pins = bp;
        repeat (2) tick();
        rstn = 1'b1;
    endtask

    task automatic wait_idle;
        int n;
        n = 0;
        while (boot_busy !== 1'b0 && n < 2000)
        begin
            tick();
            n++;
        end
        if (n == 2000)
        begin
            error_cnt++;
            $display("ERROR %0t: boot load hang", $time);
            wrap_up();
        end
    endtask

    task automatic probe(input logic [7:0] b);
        addr_byte_valid = 1'b1;
        addr_byte = b;
        #1;
        check(addr_ack, en && own != 7'h00 && b[7:1] == own);
        check(general_call, b[7:1] == 7'h00);
        tick();
    endtask

    always @(posedge clk)
    begin
        if (reg_ack === 1'b1)
        begin
            note = rd_q.size() ? rd_q.pop_front() : 33'h1_xxxx_xxxx;
            if (note[32])
                check(reg_rdata, note[31:0]);
        end
        if (boot_wr_valid === 1'b1)
            check({boot_wr_addr, boot_wr_data}, bw_q.pop_front());
    end

    initial
    begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        $display("ERROR %0t: run limit reached", $time);
        wrap_up();
    end

    initial
    begin
        clk = 1'b0;
        {reg_wr, reg_rd, addr_byte_valid, fail} = 4'h0;
        reg_addr = 32'h0000_0000;
        reg_wdata = 32'h0000_0000;
        addr_byte = 8'h00;
        void'($urandom(32'h3a3d));
        slow = 1'($urandom);
        bw_q.push_back({32'h0000_1234, 32'hA5A5_0001});
        bw_q.push_back({32'h0000_2000, 32'h5555_AAAA});
        do_reset(2'b10, 2'b01);
        wait_idle();
        tick();
        check(boot_error, 1'b0);
        check(bw_q.size(), 0);
        reg_acc(1'b0, OFF_BOOT_CTRL, 32'hA055_0010);
        reg_acc(1'b0, OFF_TARGET_ADDR, 32'h1000_0032);
        reg_acc(1'b0, OFF_DIAG_CONFIG, 32'h002A_A01C);
        reg_acc(1'b0, OFF_DIAG_PROGRESS, 32'h8000_0000);
        own = 7'h32;
        en = 1'b1;
        probe({own, 1'b0});
        probe(8'h00);
        repeat (40) probe(8'($urandom));
        reg_acc(1'b1, OFF_TARGET_ADDR, 32'h1000_0045);
        reg_acc(1'b0, OFF_TARGET_ADDR, 32'h1000_0046);
        own = 7'h46;
        probe({own, 1'b1});
        reg_acc(1'b1, OFF_TARGET_ADDR, 32'h1100_0045);
        reg_acc(1'b0, OFF_TARGET_ADDR, 32'h1100_0045);
        own = 7'h45;
        probe(8'h8A);
        reg_acc(1'b1, OFF_TARGET_ADDR, 32'h0100_0045);
        en = 1'b0;
        probe(8'h8A);
        reg_acc(1'b1, OFF_TARGET_ADDR, 32'h1100_0000);
        en = 1'b1;
        own = 7'h00;
        probe(8'h00);
        probe(8'h01);
        reg_acc(1'b1, 32'h0001_D1F0, 32'hFFFF_FFFF);
        reg_acc(1'b0, 32'h0001_D1F0, 32'h0000_0000);
        reg_acc(1'b1, OFF_BOOT_CTRL, 32'h8051_0000);
        repeat (8) tick();
        check(eeprom_req, 1'b0);
        check(boot_busy, 1'b0);
        reg_acc(1'b0, OFF_BOOT_CTRL, 32'h8051_0000);
        fail = 1'b1;
        slow = 1'($urandom);
        do_reset(2'b00, 2'b11);
        wait_idle();
        check(boot_error, 1'b1);
        check(eeprom_wide, 1'b0);
        reg_acc(1'b0, OFF_DIAG_PROGRESS, 32'h8200_0000);
        reg_acc(1'b0, OFF_BOOT_CTRL, 32'h2053_0000);
        reg_acc(1'b0, OFF_TARGET_ADDR, 32'h1000_0030);
        repeat (4) tick();
        check(rd_q.size() + bw_q.size(), 0);
        wrap_up();
    end
endmodule // i2c_slave_addr_boot_chain_ctrl_bench
`default_nettype wire
